// ===== design/pmc_pkg.sv
package pmc_pkg;

  // ****************************************************************
  // Mode field encodings
  // ****************************************************************
  localparam logic [1:0] PMC_MODE_SINGLE = 2'h0;
  localparam logic [1:0] PMC_MODE_EXPAND = 2'h1;
  localparam logic [1:0] PMC_MODE_MICRO = 2'h2;
  localparam logic [1:0] PMC_MODE_RSVD = 2'h3;
  localparam logic [1:0] PMC_MODE_RESET = PMC_MODE_SINGLE;

  // ****************************************************************
  // Field positions on the control port
  // ****************************************************************
  localparam int unsigned PMC_CTL_RDWR_BIT = 0;
  localparam int unsigned PMC_CTL_PHI_BIT = 1;
  localparam logic [7:0] PMC_CTL_BUS_MASK = 8'h03;
  localparam logic [7:0] PMC_CTL_PIN_MASK = 8'h7f;
  localparam logic [7:0] PMC_ALL_OUT = 8'hff;

  // ****************************************************************
  // Stop settling timer and clock divider
  // ****************************************************************
  localparam logic [7:0] PMC_T3_STOP_LOAD = 8'hff;
  localparam logic [7:0] PMC_T4_STOP_LOAD = 8'h03;
  localparam int unsigned PMC_T3_STOP_DIV = 16;
  localparam logic [1:0] PMC_PHI_LAST = 2'h3;
  localparam logic [1:0] PMC_PHI_RESUME = 2'h2;
  localparam int unsigned PMC_PHI_HIGH_BIT = 1;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [1:0] {
    PMC_ST_RUN,
    PMC_ST_WAIT,
    PMC_ST_STOP,
    PMC_ST_SETTLE
  } pmc_state_t;

  typedef struct packed {
    logic [7:0] dout;
    logic [7:0] oe;
  } pmc_pin_t;

  typedef struct packed {
    logic valid;
    logic rd_wr;
    logic [15:0] addr;
    logic [7:0] wdata;
  } pmc_bus_t;

endpackage

// ===== design/pmc_settle_timer.sv
`timescale 1ns/1ps
`default_nettype none
module pmc_settle_timer
  import pmc_pkg::*;
#(
  parameter int unsigned PRESCALE = PMC_T3_STOP_DIV
)
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic load,
  input wire logic run,
  output logic [7:0] t3_count,
  output logic [7:0] t4_count,
  output logic overflow
);

  // ****************************************************************
  // Prescaler feeding timer 3, timer 3 underflow feeding timer 4
  // ****************************************************************
  localparam logic [7:0] PRE_LAST = 8'(PRESCALE - 1);

  logic [7:0] pre_ff;
  logic [7:0] t3_ff;
  logic [7:0] t4_ff;
  logic ovf_ff;
  logic [7:0] nxt_pre;
  logic [7:0] nxt_t3;
  logic [7:0] nxt_t4;
  logic nxt_ovf;

  always_comb
  begin
    nxt_pre = pre_ff;
    nxt_t3 = t3_ff;
    nxt_t4 = t4_ff;
    nxt_ovf = 1'b0;
    if (load)
    begin
      nxt_pre = 8'h00;
      nxt_t3 = PMC_T3_STOP_LOAD;
      nxt_t4 = PMC_T4_STOP_LOAD;
    end
    else if (run)
    begin
      if (pre_ff == PRE_LAST)
      begin
        nxt_pre = 8'h00;
        if (t3_ff == 8'h00)
        begin
          nxt_t3 = PMC_T3_STOP_LOAD;
          nxt_t4 = t4_ff - 8'h01;
          nxt_ovf = (t4_ff == 8'h00);
        end
        else
        begin
          nxt_t3 = t3_ff - 8'h01;
        end
      end
      else
      begin
        nxt_pre = pre_ff + 8'h01;
      end
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      pre_ff <= 8'h00;
      t3_ff <= PMC_T3_STOP_LOAD;
      t4_ff <= PMC_T4_STOP_LOAD;
      ovf_ff <= 1'b0;
    end
    else
    begin
      pre_ff <= nxt_pre;
      t3_ff <= nxt_t3;
      t4_ff <= nxt_t4;
      ovf_ff <= nxt_ovf;
    end
  end

  assign t3_count = t3_ff;
  assign t4_count = t4_ff;
  assign overflow = ovf_ff;

endmodule
`default_nettype wire

// ===== design/pmc_top.sv
`timescale 1ns/1ps
`default_nettype none
module pmc_top
  import pmc_pkg::*;
#(
  parameter int unsigned STOP_PRESCALE = PMC_T3_STOP_DIV
)
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic mode_strap_pin,
  input wire logic mode_wr_en,
  input wire logic [1:0] mode_wr_data,
  output logic [1:0] mode_field,
  output logic [1:0] mode_active,
  input wire logic stop_instruction,
  input wire logic wait_instruction,
  input wire logic irq_accept,
  input wire logic irq_external,
  input wire pmc_bus_t cpu_bus,
  output logic [7:0] bus_rdata,
  input wire pmc_pin_t [3:0] gpio_drive,
  output logic [3:0][7:0] gpio_read,
  input wire logic [3:0][7:0] port_pin_in,
  output pmc_pin_t [3:0] port_pin,
  output logic oscillator_output,
  output logic sys_clk_phi,
  output logic cpu_clk_en,
  output logic int_rom_en,
  output logic timer_chain_force,
  output logic [7:0] settle_t3,
  output logic [7:0] settle_t4,
  output pmc_state_t power_state
);

  // ****************************************************************
  // Decoding helpers
  // ****************************************************************
  function automatic logic is_expanded(input logic [1:0] mode);
    is_expanded = (mode == PMC_MODE_EXPAND) || (mode == PMC_MODE_MICRO);
  endfunction

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  logic strap_meta_ff;
  logic strap_sync_ff;
  logic [3:0][7:0] pin_meta_ff;
  logic [3:0][7:0] pin_sync_ff;

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      strap_meta_ff <= 1'b0;
      strap_sync_ff <= 1'b0;
    end
    else
    begin
      strap_meta_ff <= mode_strap_pin;
      strap_sync_ff <= strap_meta_ff;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_pin_sync
      always_ff @(posedge clk_sys)
      begin
        if (rst)
        begin
          pin_meta_ff[gi] <= 8'h00;
          pin_sync_ff[gi] <= 8'h00;
        end
        else
        begin
          pin_meta_ff[gi] <= port_pin_in[gi];
          pin_sync_ff[gi] <= pin_meta_ff[gi];
        end
      end
    end
  endgenerate

  // ****************************************************************
  // Power state machine
  // ****************************************************************
  pmc_state_t state_ff;
  pmc_state_t nxt_state;
  logic osc_run_ff;
  logic nxt_osc_run;
  logic chain_ff;
  logic nxt_chain;
  logic timer_load;
  logic settle_ovf;

  always_comb
  begin
    nxt_state = state_ff;
    nxt_osc_run = osc_run_ff;
    nxt_chain = chain_ff;
    timer_load = 1'b0;
    unique case (state_ff)
      PMC_ST_RUN:
      begin
        if (stop_instruction)
        begin
          nxt_state = PMC_ST_STOP;
          nxt_osc_run = 1'b0;
          nxt_chain = 1'b1;
          timer_load = 1'b1;
        end
        else if (wait_instruction)
        begin
          nxt_state = PMC_ST_WAIT;
        end
      end
      PMC_ST_WAIT:
      begin
        if (irq_accept)
        begin
          nxt_state = PMC_ST_RUN;
        end
      end
      PMC_ST_STOP:
      begin
        if (irq_accept)
        begin
          nxt_state = PMC_ST_SETTLE;
          nxt_osc_run = 1'b1;
        end
      end
      PMC_ST_SETTLE:
      begin
        if (settle_ovf)
        begin
          nxt_state = PMC_ST_RUN;
        end
      end
    endcase
    if (irq_accept && irq_external && (state_ff != PMC_ST_RUN))
    begin
      nxt_chain = 1'b0;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      state_ff <= PMC_ST_RUN;
      osc_run_ff <= 1'b1;
      chain_ff <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      osc_run_ff <= nxt_osc_run;
      chain_ff <= nxt_chain;
    end
  end

  pmc_settle_timer #(
    .PRESCALE(STOP_PRESCALE)
  ) u_settle (
    .clk_sys(clk_sys),
    .rst(rst),
    .load(timer_load),
    .run(state_ff == PMC_ST_SETTLE),
    .t3_count(settle_t3),
    .t4_count(settle_t4),
    .overflow(settle_ovf)
  );

  // ****************************************************************
  // System clock divider
  // ****************************************************************
  logic [1:0] div_ff;
  logic [1:0] nxt_div;
  logic phi_ff;
  logic nxt_phi;
  logic tick_ff;
  logic nxt_tick;

  always_comb
  begin
    nxt_div = PMC_PHI_RESUME;
    nxt_phi = 1'b1;
    nxt_tick = 1'b0;
    if (nxt_state == PMC_ST_RUN && state_ff == PMC_ST_RUN)
    begin
      nxt_div = div_ff + 2'h1;
      nxt_phi = nxt_div[PMC_PHI_HIGH_BIT];
      nxt_tick = (div_ff == PMC_PHI_LAST);
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      div_ff <= PMC_PHI_RESUME;
      phi_ff <= 1'b1;
      tick_ff <= 1'b0;
    end
    else
    begin
      div_ff <= nxt_div;
      phi_ff <= nxt_phi;
      tick_ff <= nxt_tick;
    end
  end

  // ****************************************************************
  // Mode field
  // ****************************************************************
  logic [1:0] mode_ff;
  logic [1:0] nxt_mode;
  logic pend_ff;
  logic nxt_pend;
  logic [1:0] pend_mode_ff;
  logic [1:0] nxt_pend_mode;
  logic [1:0] eff_mode;

  always_comb
  begin
    nxt_mode = mode_ff;
    nxt_pend = pend_ff;
    nxt_pend_mode = pend_mode_ff;
    if (tick_ff && pend_ff)
    begin
      nxt_mode = pend_mode_ff;
      nxt_pend = 1'b0;
    end
    if (mode_wr_en && (mode_wr_data != PMC_MODE_RSVD))
    begin
      nxt_pend = 1'b1;
      nxt_pend_mode = mode_wr_data;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      mode_ff <= PMC_MODE_RESET;
      pend_ff <= 1'b0;
      pend_mode_ff <= PMC_MODE_RESET;
    end
    else
    begin
      mode_ff <= nxt_mode;
      pend_ff <= nxt_pend;
      pend_mode_ff <= nxt_pend_mode;
    end
  end

  assign eff_mode = strap_sync_ff ? PMC_MODE_EXPAND : mode_ff;

  // ****************************************************************
  // Port function multiplexing
  // ****************************************************************
  pmc_pin_t [3:0] pin_ff;
  pmc_pin_t [3:0] nxt_pin;
  logic [7:0] rdata_ff;
  logic [7:0] nxt_rdata;
  logic bus_wr;

  assign bus_wr = cpu_bus.valid && !cpu_bus.rd_wr;

  always_comb
  begin
    nxt_pin = gpio_drive;
    nxt_pin[3].dout = gpio_drive[3].dout & PMC_CTL_PIN_MASK;
    nxt_pin[3].oe = gpio_drive[3].oe & PMC_CTL_PIN_MASK;
    nxt_rdata = rdata_ff;
    if (is_expanded(eff_mode))
    begin
      nxt_pin[0].dout = cpu_bus.addr[7:0];
      nxt_pin[0].oe = PMC_ALL_OUT;
      nxt_pin[1].dout = cpu_bus.addr[15:8];
      nxt_pin[1].oe = PMC_ALL_OUT;
      nxt_pin[2].dout = cpu_bus.wdata;
      nxt_pin[2].oe = bus_wr ? PMC_ALL_OUT : 8'h00;
      nxt_pin[3].oe = nxt_pin[3].oe | PMC_CTL_BUS_MASK;
      nxt_pin[3].dout[PMC_CTL_RDWR_BIT] = !bus_wr;
      nxt_pin[3].dout[PMC_CTL_PHI_BIT] = nxt_phi;
      if (cpu_bus.valid && cpu_bus.rd_wr)
      begin
        nxt_rdata = pin_sync_ff[2];
      end
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      pin_ff <= '0;
      rdata_ff <= 8'h00;
    end
    else
    begin
      pin_ff <= nxt_pin;
      rdata_ff <= nxt_rdata;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign port_pin = pin_ff;
  assign gpio_read = pin_sync_ff;
  assign bus_rdata = rdata_ff;
  assign mode_field = mode_ff;
  assign mode_active = eff_mode;
  assign int_rom_en = (eff_mode != PMC_MODE_MICRO);
  assign oscillator_output = osc_run_ff;
  assign sys_clk_phi = phi_ff;
  assign cpu_clk_en = tick_ff;
  assign timer_chain_force = chain_ff;
  assign power_state = state_ff;

endmodule
`default_nettype wire

// ===== verification/pmc_props.sv
`timescale 1ns/1ps
`default_nettype none
module pmc_props
  import pmc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic mode_strap_pin,
  input wire logic mode_wr_en,
  input wire logic [1:0] mode_wr_data,
  input wire logic [1:0] mode_field,
  input wire logic [1:0] mode_active,
  input wire logic stop_instruction,
  input wire logic irq_accept,
  input wire logic irq_external,
  input wire pmc_bus_t cpu_bus,
  input wire pmc_pin_t [3:0] gpio_drive,
  input wire pmc_pin_t [3:0] port_pin,
  input wire logic oscillator_output,
  input wire logic sys_clk_phi,
  input wire logic int_rom_en,
  input wire logic timer_chain_force,
  input wire logic [7:0] settle_t3,
  input wire logic [7:0] settle_t4,
  input wire pmc_state_t power_state
);
  // ****************
  // Checks
  // ****************
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  sequence s_wr;
    mode_wr_en && mode_wr_data != PMC_MODE_RSVD;
  endsequence
  sequence s_quiet;
    (!mode_wr_en && power_state == PMC_ST_RUN)[*6];
  endsequence
  sequence s_stop;
    power_state == PMC_ST_RUN && stop_instruction;
  endsequence
  a_strap_forces: assert property (mode_strap_pin[*3] |=>
    mode_active == PMC_MODE_EXPAND) else $error("strap mode wrong");
  a_field_write: assert property (s_wr ##1 s_quiet |->
    mode_field == $past(mode_wr_data, 6)) else $error("write lost");
  a_rom_mode: assert property ($stable(mode_active) |->
    int_rom_en == (mode_active != PMC_MODE_MICRO)) else $error("rom");
  a_stop_entry: assert property (s_stop |=>
    power_state == PMC_ST_STOP && !oscillator_output && timer_chain_force
    && settle_t3 == 8'hff && settle_t4 == 8'h03) else $error("stop");
  a_phi_held: assert property (power_state != PMC_ST_RUN |->
    sys_clk_phi) else $error("phi not high");
  a_wait_exit: assert property (power_state == PMC_ST_WAIT &&
    irq_accept |=> power_state == PMC_ST_RUN) else $error("wait exit");
  a_chain_drop: assert property (power_state != PMC_ST_RUN &&
    irq_accept && irq_external |=> !timer_chain_force) else $error("chain");
  a_phi_quarter: assert property ((power_state == PMC_ST_RUN)[*8] |->
    sys_clk_phi != $past(sys_clk_phi, 2)) else $error("phi rate");
  a_addr_out: assert property (mode_active != PMC_MODE_SINGLE &&
    cpu_bus.valid |=> port_pin[0].dout == $past(cpu_bus.addr[7:0])
    && port_pin[1].oe == 8'hff) else $error("address port");
  a_gpio_pass: assert property (mode_active == PMC_MODE_SINGLE |=>
    port_pin[0] == $past(gpio_drive[0])) else $error("gpio port");
endmodule
bind pmc_top pmc_props u_props (.clk_sys, .rst, .mode_strap_pin,
  .mode_wr_en, .mode_wr_data, .mode_field, .mode_active,
  .stop_instruction, .irq_accept, .irq_external, .cpu_bus, .gpio_drive,
  .port_pin, .oscillator_output, .sys_clk_phi, .int_rom_en,
  .timer_chain_force, .settle_t3, .settle_t4, .power_state);
`default_nettype wire

// ===== verification/pmc_ext_mem.sv
`timescale 1ns/1ps
`default_nettype none
module pmc_ext_mem
  import pmc_pkg::*;
(
  input wire logic clk_sys,
  input wire pmc_pin_t [3:0] port_pin,
  output logic [3:0][7:0] port_pin_in
);
  // ****************
  // Outside memory
  // ****************
  logic [7:0] last_ff;
  always_ff @(posedge clk_sys)
    last_ff <= port_pin_in[2];
  // Released lines read the inverse of port 2's last input, except port 2 when fully released with R/W high
  always_comb
  begin
    for (int i = 0; i < 4; i++)
      port_pin_in[i] = (port_pin[i].dout & port_pin[i].oe)
        | (~last_ff & ~port_pin[i].oe);
    if (port_pin[2].oe == 8'h00 && port_pin[3].dout[PMC_CTL_RDWR_BIT])
      port_pin_in[2] = port_pin[0].dout ^ port_pin[1].dout ^ 8'h5a;
  end
endmodule
`default_nettype wire

// ===== verification/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import pmc_pkg::*;
  // ****************
  // Signals
  // ****************
  localparam int unsigned PS = 2;
  localparam int SETTLE = 256 * 4 * PS + 1;
  logic clk_sys, rst, mode_strap_pin, mode_wr_en;
  logic stop_instruction, wait_instruction, irq_accept, irq_external;
  logic [1:0] mode_wr_data, mode_field, mode_active, e;
  pmc_bus_t cpu_bus;
  pmc_pin_t [3:0] gpio_drive, port_pin;
  logic [3:0][7:0] gpio_read, port_pin_in;
  logic [7:0] bus_rdata, settle_t3, settle_t4;
  logic oscillator_output, sys_clk_phi, cpu_clk_en, int_rom_en;
  logic timer_chain_force;
  pmc_state_t power_state;
  logic [1:0] wseq [4] = '{2'h1, 2'h3, 2'h2, 2'h3};
  int mismatches, total_checks, cyc, n, k;

  pmc_top #(.STOP_PRESCALE(PS)) uut (.clk_sys, .rst, .mode_strap_pin,
    .mode_wr_en, .mode_wr_data, .mode_field, .mode_active,
    .stop_instruction, .wait_instruction, .irq_accept, .irq_external,
    .cpu_bus, .bus_rdata, .gpio_drive, .gpio_read, .port_pin_in,
    .port_pin, .oscillator_output, .sys_clk_phi, .cpu_clk_en,
    .int_rom_en, .timer_chain_force, .settle_t3, .settle_t4,
    .power_state);
  pmc_ext_mem u_mem (.clk_sys, .port_pin, .port_pin_in);

  initial
  begin
    clk_sys = 0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      mismatches++;
      close_out();
    end
  end
  // ****************
  // Tasks
  // ****************
  task automatic tick(int k);
    repeat (k) @(posedge clk_sys);
    #1;
  endtask
  task automatic chk(string s, logic [15:0] x, logic [15:0] g);
    total_checks++;
    if (g !== x)
    begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", s, x, g);
    end
  endtask
  task automatic wr_mode(logic [1:0] d);
    mode_wr_en = 1;
    mode_wr_data = d;
    tick(1);
    mode_wr_en = 0;
    tick(8);
  endtask
  task automatic pulse_irq(logic ext);
    irq_accept = 1;
    irq_external = ext;
    tick(1);
    irq_accept = 0;
    irq_external = 0;
  endtask
  task automatic do_stop();
    stop_instruction = 1;
    tick(1);
    stop_instruction = 0;
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // ****************
  // Tests
  // ****************
  initial
  begin
    rst = 1;
    mode_strap_pin = 0;
    mode_wr_en = 0;
    mode_wr_data = 0;
    stop_instruction = 0;
    wait_instruction = 0;
    irq_accept = 0;
    irq_external = 0;
    cpu_bus = '0;
    gpio_drive = {4{16'ha5ff}};
    tick(20);
    rst = 0;
    tick(2);
    chk("mode", 2'h0, mode_field);
    chk("t3", 8'hff, settle_t3);
    chk("t4", 8'h03, settle_t4);
    chk("p0", 16'ha5ff, port_pin[0]);
    chk("p3", 8'h25, port_pin[3].dout);
    $display("test reset done");
    e = 2'h0;
    foreach (wseq[i])
    begin
      wr_mode(wseq[i]);
      if (wseq[i] != PMC_MODE_RSVD)
        e = wseq[i];
      chk("mode", e, mode_field);
      chk("rom", e != PMC_MODE_MICRO, int_rom_en);
    end
    cpu_bus = '{1'b1, 1'b0, 16'h12c3, 8'h3c};
    tick(2);
    chk("p0", 8'hc3, port_pin[0].dout);
    chk("p1", 8'h12, port_pin[1].dout);
    chk("p2", 16'h3cff, port_pin[2]);
    chk("rw", 1'b0, port_pin[3].dout[0]);
    n = 0;
    k = 0;
    repeat (8)
    begin
      n += int'(port_pin[3].dout[1]) + int'(sys_clk_phi);
      k += int'(cpu_clk_en);
      tick(1);
    end
    chk("phi", 16'h0008, n);
    chk("clk_en", 16'h0002, k);
    cpu_bus = '{1'b1, 1'b1, 16'h0456, 8'h00};
    tick(5);
    chk("p2oe", 8'h00, port_pin[2].oe);
    chk("rw", 1'b1, port_pin[3].dout[0]);
    chk("rd", 8'h56 ^ 8'h04 ^ 8'h5a, bus_rdata);
    cpu_bus.valid = 0;
    wr_mode(2'h0);
    chk("p0", 16'ha5ff, port_pin[0]);
    chk("gpio0", 8'ha5, gpio_read[0]);
    chk("gpio3", 8'h25, gpio_read[3]);
    $display("test modes done");
    mode_strap_pin = 1;
    tick(3);
    chk("act", 2'h1, mode_active);
    wr_mode(2'h2);
    chk("act", 2'h1, mode_active);
    mode_strap_pin = 0;
    tick(3);
    chk("act", 2'h2, mode_active);
    wr_mode(2'h0);
    $display("test strap done");
    wait_instruction = 1;
    tick(1);
    wait_instruction = 0;
    tick(4);
    chk("ps", PMC_ST_WAIT, power_state);
    chk("phi", 1'b1, sys_clk_phi);
    chk("osc", 1'b1, oscillator_output);
    pulse_irq(1'b0);
    chk("ps", PMC_ST_RUN, power_state);
    $display("test wait done");
    do_stop();
    chk("ps", PMC_ST_STOP, power_state);
    chk("osc", 1'b0, oscillator_output);
    chk("chain", 1'b1, timer_chain_force);
    tick(4);
    pulse_irq(1'b1);
    chk("ps", PMC_ST_SETTLE, power_state);
    chk("osc", 1'b1, oscillator_output);
    chk("chain", 1'b0, timer_chain_force);
    n = 0;
    while (power_state == PMC_ST_SETTLE && n < 5000)
    begin
      tick(1);
      n++;
    end
    chk("settle", SETTLE, n);
    do_stop();
    chk("chain", 1'b1, timer_chain_force);
    rst = 1;
    tick(1);
    rst = 0;
    tick(1);
    chk("chain", 1'b0, timer_chain_force);
    $display("test stop done");
    close_out();
  end
endmodule
`default_nettype wire
